// file: hw/i2c_slave_pkg.sv
`default_nettype none
package i2c_slave_pkg;
	// Host bit timing: one SCL bit is four quarters, least quarter time in ns
	localparam int CORE_CLK_MHZ = 100;
	localparam int QUARTER_NS = 2500;
	localparam int QUARTER_CYCLES = (QUARTER_NS * CORE_CLK_MHZ + 999) / 1000;

	// Address and byte framing
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Host command codes
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} host_cmd_t;
endpackage : i2c_slave_pkg
`default_nettype wire

// file: hw/i2c_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
	// Open-drain pins: output value is always low, enable pulls the wire
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_scl_out;
	logic dev_scl_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND bus with pull-up
	assign scl = !(host_scl_oe || dev_scl_oe);
	assign sda = !(host_sda_oe || dev_sda_oe);

	modport host (output host_scl_out, output host_scl_oe, output host_sda_out,
		output host_sda_oe, input scl, input sda);
	modport device (output dev_scl_out, output dev_scl_oe, output dev_sda_out,
		output dev_sda_oe, input scl, input sda);
endinterface : i2c_link_if
`default_nettype wire

// file: hw/i2c_bus_host.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_host import i2c_slave_pkg::*; #(
	parameter int QUARTER = QUARTER_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic cmd_valid_in,
	input wire host_cmd_t cmd_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic cmd_nack_in,
	output logic cmd_ready_out,
	output logic done_out,
	output logic [7:0] rd_data_out,
	output logic slave_nack_out,
	i2c_link_if.host link
);
	localparam int QW = (QUARTER > 1) ? $clog2(QUARTER) : 1;

	typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} host_state_t;

	host_state_t state;
	logic [1:0] step;
	logic [QW-1:0] qcnt;
	logic [3:0] bit_n;
	logic [8:0] txv;
	logic [8:0] rxv;
	logic scl_low;
	logic sda_low;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic stall;
	logic tick;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end else begin
			scl_sync <= {scl_sync[0], link.scl};
			sda_sync <= {sda_sync[0], link.sda};
		end
	end

	// Released SCL waits while the slave stretches it
	assign stall = (step == 2'h1) && !scl_sync[1];
	assign tick = (qcnt == QW'(QUARTER - 1));
	assign cmd_ready_out = (state == H_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Quarter-step sequencer for start, stop and bits
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state <= H_IDLE;
			step <= 2'h0;
			qcnt <= '0;
			bit_n <= 4'h0;
			txv <= 9'h1ff;
			rxv <= 9'h000;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			done_out <= 1'b0;
			rd_data_out <= BYTE_RESET;
			slave_nack_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state)
				H_IDLE: begin
					if (cmd_valid_in) begin
						step <= 2'h0;
						qcnt <= '0;
						bit_n <= 4'h0;
						case (cmd_in)
							CMD_START: begin
								sda_low <= 1'b0;
								state <= H_START;
							end
							CMD_STOP: begin
								sda_low <= 1'b1;
								state <= H_STOP;
							end
							CMD_WRITE: begin
								txv <= {cmd_data_in, 1'b1};
								sda_low <= !cmd_data_in[7];
								state <= H_BIT;
							end
							default: begin
								txv <= {8'hff, cmd_nack_in}; // see R19
								sda_low <= 1'b0;
								state <= H_BIT;
							end
						endcase
					end
				end
				default: begin
					if (!stall && !tick) begin
						qcnt <= qcnt + 1'b1;
					end else if (!stall) begin
						qcnt <= '0;
						step <= step + 1'b1;
						case (step)
							2'h0: scl_low <= 1'b0;
							2'h1: begin
								if (state == H_START) begin
									sda_low <= 1'b1;
								end else if (state == H_STOP) begin
									sda_low <= 1'b0;
								end else begin
									rxv <= {rxv[7:0], sda_sync[1]};
								end
							end
							2'h2: scl_low <= (state != H_STOP);
							default: begin
								if (state == H_BIT && bit_n != BITS_PER_BYTE) begin
									bit_n <= bit_n + 1'b1;
									txv <= {txv[7:0], 1'b1};
									sda_low <= !txv[7];
								end else begin
									state <= H_IDLE;
									done_out <= 1'b1;
									rd_data_out <= rxv[8:1];
									slave_nack_out <= rxv[0];
								end
							end
						endcase
					end
				end
			endcase
		end
	end

	// Open-drain drive
	assign link.host_scl_out = 1'b0;
	assign link.host_sda_out = 1'b0;
	assign link.host_scl_oe = scl_low;
	assign link.host_sda_oe = sda_low;
endmodule : i2c_bus_host
`default_nettype wire

// file: hw/i2c_slave_device.sv
// Function
// R1: Software enables, sets ACK reply, selects mode
// R2: Ten-bit address from two register parts
// R3: Seven-bit write match: ack, flag, direction zero
// R4: Hold SCL after write match until serviced
// R5: Status read clears address-match flag
// R6: Reply-bit ack, then set receive-full flag
// R7: Data read clears receive-full flag
// R8: Software sets NACK ahead of last byte
// R9: Stop or restart while addressed sets flag
// R10: Status read clears stop/restart flag
// R11: Ten-bit header write with matching bits: ack
// R12: Second byte match: flag, direction zero, ack
// R13: Seven-bit read match: ack, flag, direction one
// R14: Stretch SCL until first transmit byte written
// R15: Transmit enable gates transmit-empty interrupt
// R16: First bit out sets transmit-empty flag
// R17: Data write clears transmit-empty flag
// R18: Empty register at next MSB stretches SCL
// R19: Master acks each read byte, NACKs last
// R20: Master NACK sets not-acknowledge flag
// R21: Flush discards pending transmit byte
// R22: General call sets match and general-call flags
// R23: Never acknowledge a START byte
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_device import i2c_slave_pkg::*; (
	input wire logic link_clk_in,
	input wire logic sys_rst_in,
	input wire logic controller_enable_in,
	input wire logic ten_bit_mode_in,
	input wire logic general_call_enable_in,
	input wire logic [9:0] own_address_in,
	input wire logic reply_nack_in,
	input wire logic transmit_irq_enable_in,
	input wire logic flush_in,
	input wire logic status_read_in,
	input wire logic data_read_in,
	input wire logic data_write_in,
	input wire logic [7:0] data_wr_in,
	output logic [7:0] rx_data_out,
	output logic address_match_flag_out,
	output logic general_call_seen_out,
	output logic read_dir_out,
	output logic rx_full_flag_out,
	output logic tx_empty_flag_out,
	output logic nack_seen_flag_out,
	output logic stop_restart_flag_out,
	output logic irq_out,
	i2c_link_if.device link
);
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR1, S_ADDR2, S_RX, S_ACK, S_HOLD, S_TXLOAD, S_TX, S_MACK, S_WAIT
	} slave_state_t;

	slave_state_t state;
	slave_state_t after_ack;
	slave_state_t next_after;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_d;
	logic sda_d;
	logic scl_now;
	logic sda_now;
	logic rise;
	logic fall;
	logic start_det;
	logic stop_det;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic sda_low;
	logic active;
	logic ten_hit;
	logic [7:0] tx_buf;
	logic tx_full;
	logic byte_end;
	logic hit_ack;
	logic hit_sam;
	logic hit_gc;
	logic hit_rd;
	logic hit_ten;
	logic ev_sam;
	logic ev_rx;
	logic load_tx;
	logic first_rise;
	logic ev_nack;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus condition detection
	always_ff @(posedge link_clk_in) begin
		if (sys_rst_in) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], link.scl};
			sda_sync <= {sda_sync[0], link.sda};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end

	assign scl_now = scl_sync[1];
	assign sda_now = sda_sync[1];
	assign rise = scl_now && !scl_d;
	assign fall = !scl_now && scl_d;
	assign start_det = scl_now && scl_d && sda_d && !sda_now;
	assign stop_det = scl_now && scl_d && !sda_d && sda_now;

	////////////////////////////////////////////////////////////////////////
	// Decode of a completed received byte
	always_comb begin
		hit_ack = 1'b0;
		hit_sam = 1'b0;
		hit_gc = 1'b0;
		hit_rd = 1'b0;
		hit_ten = 1'b0;
		next_after = S_WAIT;
		if (state == S_ADDR1 && controller_enable_in) begin // see R1
			if (!ten_bit_mode_in && shreg[7:1] == own_address_in[6:0]
				&& shreg[7:1] != GENERAL_CALL_ADDR) begin
				hit_ack = 1'b1; // see R3, R13
				hit_sam = 1'b1;
				hit_rd = shreg[0];
				next_after = shreg[0] ? S_TXLOAD : S_HOLD;
			end else if (shreg[7:1] == GENERAL_CALL_ADDR) begin
				// START byte has direction one and is never answered
				hit_ack = general_call_enable_in && !shreg[0]; // see R22, R23
				hit_sam = hit_ack;
				hit_gc = hit_ack;
				next_after = S_HOLD;
			end else if (ten_bit_mode_in && shreg[7:3] == TEN_BIT_PREFIX
				&& shreg[2:1] == own_address_in[9:8]) begin // see R2
				if (!shreg[0]) begin
					hit_ack = 1'b1; // see R11
					next_after = S_ADDR2;
				end else if (ten_hit) begin
					hit_ack = 1'b1;
					hit_sam = 1'b1;
					hit_rd = 1'b1;
					next_after = S_TXLOAD;
				end
			end
		end else if (state == S_ADDR2 && shreg == own_address_in[7:0]) begin // see R2
			hit_ack = 1'b1; // see R12
			hit_sam = 1'b1;
			hit_ten = 1'b1;
			next_after = S_HOLD;
		end else if (state == S_RX) begin
			hit_ack = !reply_nack_in; // see R6, R8
			next_after = S_RX;
		end
	end

	assign byte_end = fall && bit_cnt == BITS_PER_BYTE
		&& (state == S_ADDR1 || state == S_ADDR2 || state == S_RX);
	assign ev_sam = byte_end && hit_sam;
	assign ev_rx = byte_end && state == S_RX;
	assign load_tx = state == S_TXLOAD && tx_full;
	assign first_rise = state == S_TX && rise && bit_cnt == 4'h0;
	assign ev_nack = state == S_MACK && rise && sda_now;

	////////////////////////////////////////////////////////////////////////
	// Transaction state machine
	always_ff @(posedge link_clk_in) begin
		if (sys_rst_in) begin
			state <= S_IDLE;
			after_ack <= S_IDLE;
			bit_cnt <= 4'h0;
			shreg <= BYTE_RESET;
			sda_low <= 1'b0;
		end else if (start_det) begin
			state <= S_ADDR1;
			bit_cnt <= 4'h0;
			sda_low <= 1'b0;
		end else if (stop_det) begin
			state <= S_IDLE;
			sda_low <= 1'b0;
		end else begin
			case (state)
				S_ADDR1, S_ADDR2, S_RX: begin
					if (rise) begin
						shreg <= {shreg[6:0], sda_now};
						bit_cnt <= bit_cnt + 1'b1;
					end
					if (byte_end) begin
						bit_cnt <= 4'h0;
						sda_low <= hit_ack;
						state <= S_ACK;
						after_ack <= (hit_ack || state == S_RX) ? next_after : S_WAIT;
					end
				end
				S_ACK: begin
					if (fall) begin
						sda_low <= 1'b0;
						state <= after_ack;
					end
				end
				S_HOLD: begin
					if (!address_match_flag_out) begin
						state <= S_RX;
					end
				end
				S_TXLOAD: begin
					if (tx_full) begin
						shreg <= tx_buf;
						sda_low <= !tx_buf[7];
						bit_cnt <= 4'h0;
						state <= S_TX;
					end
				end
				S_TX: begin
					if (rise) begin
						bit_cnt <= bit_cnt + 1'b1;
					end
					if (fall && bit_cnt == BITS_PER_BYTE) begin
						sda_low <= 1'b0;
						state <= S_MACK;
					end else if (fall) begin
						shreg <= {shreg[6:0], 1'b0};
						sda_low <= !shreg[6];
					end
				end
				S_MACK: begin
					if (ev_nack) begin
						state <= S_WAIT;
					end else if (fall) begin
						state <= S_TXLOAD; // see R19
					end
				end
				default: begin
					sda_low <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Addressed-session tracking
	always_ff @(posedge link_clk_in) begin
		if (sys_rst_in) begin
			active <= 1'b0;
			ten_hit <= 1'b0;
		end else begin
			if (ev_sam) begin
				active <= 1'b1;
			end else if (start_det || stop_det) begin
				active <= 1'b0;
			end
			if (byte_end && hit_ten) begin
				ten_hit <= 1'b1;
			end else if (stop_det) begin
				ten_hit <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags, set wins over clear
	always_ff @(posedge link_clk_in) begin
		if (sys_rst_in) begin
			address_match_flag_out <= 1'b0;
			general_call_seen_out <= 1'b0;
			read_dir_out <= 1'b0;
			stop_restart_flag_out <= 1'b0;
			nack_seen_flag_out <= 1'b0;
		end else begin
			if (ev_sam) begin
				address_match_flag_out <= 1'b1;
				general_call_seen_out <= hit_gc; // see R22
				read_dir_out <= hit_rd; // see R3, R12, R13
			end else if (status_read_in) begin
				address_match_flag_out <= 1'b0; // see R5
				general_call_seen_out <= 1'b0;
			end
			if ((start_det || stop_det) && active) begin
				stop_restart_flag_out <= 1'b1; // see R9
			end else if (status_read_in) begin
				stop_restart_flag_out <= 1'b0; // see R10
			end
			if (ev_nack) begin
				nack_seen_flag_out <= 1'b1; // see R20
			end else if (status_read_in) begin
				nack_seen_flag_out <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive data holding
	always_ff @(posedge link_clk_in) begin
		if (sys_rst_in) begin
			rx_full_flag_out <= 1'b0;
			rx_data_out <= BYTE_RESET;
		end else begin
			if (ev_rx) begin
				rx_full_flag_out <= 1'b1; // see R6
				rx_data_out <= shreg;
			end else if (data_read_in) begin
				rx_full_flag_out <= 1'b0; // see R7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit data holding
	always_ff @(posedge link_clk_in) begin
		if (sys_rst_in) begin
			tx_full <= 1'b0;
			tx_buf <= BYTE_RESET;
			tx_empty_flag_out <= 1'b0;
		end else begin
			if (data_write_in) begin
				tx_full <= 1'b1;
				tx_buf <= data_wr_in;
			end else if (load_tx || flush_in) begin
				tx_full <= 1'b0; // see R21
			end
			if (first_rise) begin
				tx_empty_flag_out <= 1'b1; // see R16
			end else if (data_write_in) begin
				tx_empty_flag_out <= 1'b0; // see R17
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt and pin drive
	assign irq_out = address_match_flag_out || rx_full_flag_out || nack_seen_flag_out
		|| stop_restart_flag_out
		|| (tx_empty_flag_out && transmit_irq_enable_in); // see R15
	assign link.dev_scl_out = 1'b0;
	assign link.dev_sda_out = 1'b0;
	// Clock stays held through the load cycle, so the first bit reaches SDA on the same edge that releases it
	assign link.dev_scl_oe = (state == S_HOLD && address_match_flag_out) // see R4
		|| (state == S_TXLOAD); // see R14, R18
	assign link.dev_sda_oe = sda_low;
endmodule : i2c_slave_device
`default_nettype wire

// file: verif/i2c_slave_engine_props.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_engine_props (
	input wire logic link_clk_in,
	input wire logic sys_rst_in,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic status_read_in,
	input wire logic data_read_in,
	input wire logic data_write_in,
	input wire logic transmit_irq_enable_in,
	input wire logic address_match_flag_out,
	input wire logic general_call_seen_out,
	input wire logic read_dir_out,
	input wire logic rx_full_flag_out,
	input wire logic tx_empty_flag_out,
	input wire logic nack_seen_flag_out,
	input wire logic stop_restart_flag_out,
	input wire logic irq_out
);
	default clocking cb @(posedge link_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic others;
	// Any flag apart from transmit-empty
	assign others = address_match_flag_out || general_call_seen_out || rx_full_flag_out
		|| nack_seen_flag_out || stop_restart_flag_out;
	////////////////////////////////////////////////////////////
	property p_wr_hold;
		address_match_flag_out && !read_dir_out && dev_scl_oe && !status_read_in |=> dev_scl_oe;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("clock hold dropped before service");
	property p_sr_clear;
		status_read_in |=> !address_match_flag_out && !stop_restart_flag_out;
	endproperty
	a_sr_clear: assert property (p_sr_clear) else $error("status read left a flag");
	property p_rd_clear;
		data_read_in |=> !rx_full_flag_out;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("data read left rx flag");
	property p_wr_clear;
		data_write_in |=> !tx_empty_flag_out;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("data write left tx flag");
	property p_irq_gate;
		tx_empty_flag_out && !others |-> irq_out == transmit_irq_enable_in;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("tx interrupt not gated");
	property p_irq_raise;
		rx_full_flag_out || stop_restart_flag_out || nack_seen_flag_out |-> irq_out;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("flag without interrupt");
	property p_ack_match;
		$rose(address_match_flag_out) |-> dev_sda_oe;
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("match without ack");
	property p_nack_flag;
		$rose(nack_seen_flag_out) |-> read_dir_out && scl && sda;
	endproperty
	a_nack_flag: assert property (p_nack_flag) else $error("nack flag without nack");
	property p_sr_flag;
		$rose(stop_restart_flag_out) |-> scl;
	endproperty
	a_sr_flag: assert property (p_sr_flag) else $error("stop flag with clock low");
	property p_tx_stretch;
		tx_empty_flag_out && read_dir_out && !address_match_flag_out && dev_scl_oe
			&& !data_write_in && $past(dev_scl_oe) |=> dev_scl_oe;
	endproperty
	a_tx_stretch: assert property (p_tx_stretch) else $error("stretch ended while empty");
	// Main scenarios reached
	c_read: cover property ($rose(address_match_flag_out) && read_dir_out);
	c_nack: cover property ($rose(nack_seen_flag_out));
	c_stop: cover property ($rose(stop_restart_flag_out));
endmodule : i2c_slave_engine_props
`default_nettype wire

// file: verif/tb_i2c_slave_transaction_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_transaction_engine import i2c_slave_pkg::*; ();
	logic core_clk, lclk, rst, cmd_valid, cmd_nack, cmd_ready, done, slave_nack;
	host_cmd_t cmd_op;
	logic [7:0] cmd_data, rd_data, rx_data, data_wr;
	logic en, ten, general_call_enable, rnack, txie, flush, sread, dread, dwrite;
	logic [9:0] own;
	logic amf, gcs, rdir, rxf, txe, nkf, srf, irq;
	logic [7:0] bad [2];
	int err_total, n_checks;
	i2c_link_if link_bus ();
	////////////////////////////////////////////////////////////
	// Bus master end and addressed end
	i2c_bus_host #(.QUARTER(8)) u_i2c_bus_host (.core_clk_in(core_clk), .sys_rst_in(rst),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd_op), .cmd_data_in(cmd_data),
		.cmd_nack_in(cmd_nack), .cmd_ready_out(cmd_ready), .done_out(done),
		.rd_data_out(rd_data), .slave_nack_out(slave_nack), .link(link_bus));
	i2c_slave_device u_i2c_slave_device (.link_clk_in(lclk), .sys_rst_in(rst),
		.controller_enable_in(en), .ten_bit_mode_in(ten), .general_call_enable_in(general_call_enable),
		.own_address_in(own), .reply_nack_in(rnack), .transmit_irq_enable_in(txie),
		.flush_in(flush), .status_read_in(sread), .data_read_in(dread),
		.data_write_in(dwrite), .data_wr_in(data_wr), .rx_data_out(rx_data),
		.address_match_flag_out(amf), .general_call_seen_out(gcs), .read_dir_out(rdir),
		.rx_full_flag_out(rxf), .tx_empty_flag_out(txe), .nack_seen_flag_out(nkf),
		.stop_restart_flag_out(srf), .irq_out(irq), .link(link_bus));
	i2c_slave_engine_props u_i2c_slave_engine_props (.link_clk_in(lclk), .sys_rst_in(rst),
		.dev_scl_oe(link_bus.dev_scl_oe), .dev_sda_oe(link_bus.dev_sda_oe),
		.scl(link_bus.scl), .sda(link_bus.sda), .status_read_in(sread),
		.data_read_in(dread), .data_write_in(dwrite), .transmit_irq_enable_in(txie),
		.address_match_flag_out(amf), .general_call_seen_out(gcs), .read_dir_out(rdir),
		.rx_full_flag_out(rxf), .tx_empty_flag_out(txe), .nack_seen_flag_out(nkf),
		.stop_restart_flag_out(srf), .irq_out(irq));
	////////////////////////////////////////////////////////////
	// Clocks, the link clock on an unrelated phase
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		lclk = 1'b0;
		#3;
		forever #6 lclk = ~lclk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One host command, waits for its completion
	task automatic cmd(input host_cmd_t c, input logic [7:0] d, input logic nk);
		int n;
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_op = c;
		cmd_data = d;
		cmd_nack = nk;
		@(posedge core_clk);
		while (cmd_ready !== 1'b1) @(posedge core_clk);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge core_clk);
			n++;
		end
		chk(8'(n < 20000), 8'h01);
		repeat (8) @(negedge core_clk);
	endtask : cmd
	// Software pulses: flush, status read, data read, data write
	task automatic dp(input logic [3:0] m, input logic [7:0] d);
		@(negedge lclk);
		{flush, sread, dread, dwrite} = m;
		data_wr = d;
		@(negedge lclk);
		{flush, sread, dread, dwrite} = 4'h0;
		repeat (2) @(negedge lclk);
	endtask : dp
	task automatic addr(input logic [7:0] a, input logic nk);
		cmd(CMD_START, 8'h00, 1'b0);
		cmd(CMD_WRITE, a, 1'b0);
		chk(slave_nack, nk);
	endtask : addr
	// Clock line must be pulled by the addressed end
	task automatic held();
		repeat (40) @(negedge core_clk);
		chk({link_bus.dev_scl_oe, link_bus.scl}, 8'h02);
	endtask : held
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// Watchdog
	initial begin
		#300us;
		err_total++;
		summarize();
	end
	////////////////////////////////////////////////////////////
	initial begin
		{rst, cmd_valid, cmd_nack, cmd_data, data_wr} = {1'b1, 1'b0, 1'b0, 16'h0000};
		cmd_op = CMD_START;
		{en, ten, general_call_enable, rnack, txie, flush, sread, dread, dwrite} = 9'h140;
		own = 10'h02a;
		bad = '{8'h56, 8'h01};
		err_total = 0;
		n_checks = 0;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge lclk);
		en = 1'b0;
		addr(8'h54, 1'b1);
		@(negedge lclk);
		en = 1'b1;
		foreach (bad[i]) addr(bad[i], 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0);
		chk(srf, 1'b0);
		addr(8'h00, 1'b0);
		chk({gcs, amf}, 8'h03);
		held();
		dp(4'h4, 8'h00);
		chk({gcs, amf}, 8'h00);
		cmd(CMD_STOP, 8'h00, 1'b0);
		dp(4'h4, 8'h00);
		$display("test refuse done");
		addr(8'h54, 1'b0);
		chk({amf, rdir}, 8'h02);
		held();
		dp(4'h4, 8'h00);
		chk(amf, 1'b0);
		cmd(CMD_WRITE, 8'ha5, 1'b0);
		chk({slave_nack, rxf, irq}, 8'h03);
		chk(rx_data, 8'ha5);
		dp(4'h2, 8'h00);
		chk(rxf, 1'b0);
		@(negedge lclk);
		rnack = 1'b1;
		cmd(CMD_WRITE, 8'h3c, 1'b0);
		chk(slave_nack, 1'b1);
		chk(rx_data, 8'h3c);
		dp(4'h2, 8'h00);
		rnack = 1'b0;
		cmd(CMD_STOP, 8'h00, 1'b0);
		chk(srf, 1'b1);
		dp(4'h4, 8'h00);
		chk(srf, 1'b0);
		$display("test write done");
		addr(8'h55, 1'b0);
		chk({amf, rdir}, 8'h03);
		dp(4'h4, 8'h00);
		fork
			cmd(CMD_READ, 8'h00, 1'b0);
			begin
				held();
				dp(4'h1, 8'hc3);
			end
		join
		chk(rd_data, 8'hc3);
		chk({txe, irq}, 8'h02);
		@(negedge lclk);
		txie = 1'b1;
		@(negedge lclk);
		chk(irq, 1'b1);
		dp(4'h1, 8'h5e);
		chk(txe, 1'b0);
		cmd(CMD_READ, 8'h00, 1'b0);
		chk(txe, 1'b1);
		chk(rd_data, 8'h5e);
		fork
			cmd(CMD_READ, 8'h00, 1'b1);
			begin
				held();
				dp(4'h1, 8'h81);
			end
		join
		chk(nkf, 1'b1);
		chk(rd_data, 8'h81);
		@(negedge lclk);
		txie = 1'b0;
		dp(4'h1, 8'hff);
		dp(4'h8, 8'h00);
		cmd(CMD_STOP, 8'h00, 1'b0);
		chk(srf, 1'b1);
		dp(4'h4, 8'h00);
		addr(8'h55, 1'b0);
		dp(4'h4, 8'h00);
		fork
			cmd(CMD_READ, 8'h00, 1'b1);
			begin
				held();
				dp(4'h1, 8'h77);
			end
		join
		chk(rd_data, 8'h77);
		cmd(CMD_STOP, 8'h00, 1'b0);
		dp(4'h4, 8'h00);
		$display("test read done");
		@(negedge lclk);
		ten = 1'b1;
		own = 10'h2c5;
		addr(8'hf6, 1'b1);
		addr(8'hf4, 1'b0);
		chk(amf, 1'b0);
		cmd(CMD_WRITE, 8'hc5, 1'b0);
		chk({slave_nack, amf, rdir}, 8'h02);
		dp(4'h4, 8'h00);
		cmd(CMD_STOP, 8'h00, 1'b0);
		dp(4'h4, 8'h00);
		$display("test ten done");
		summarize();
	end
endmodule : tb_i2c_slave_transaction_engine
`default_nettype wire
